// ===== design/i2css_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef I2CSS_MAP_SVH
`define I2CSS_MAP_SVH
`define I2CSS_ADDR_CTRL1 3'h0
`define I2CSS_ADDR_CTRL2 3'h1
`define I2CSS_ADDR_STATUS 3'h2
`define I2CSS_ADDR_DATA 3'h3
`define I2CSS_ADDR_OWN 3'h4
`define I2CSS_ADDR_IRQ_STAT 3'h5
`define I2CSS_ADDR_IRQ_MASK 3'h6
`define I2CSS_CR2_MST 7
`define I2CSS_CR2_TRX 6
`define I2CSS_CR2_BB 5
`define I2CSS_CR2_PIN 4
`define I2CSS_SR_AL 3
`define I2CSS_SR_AAS 2
`define I2CSS_SR_AD0 1
`define I2CSS_SR_LRB 0
`define I2CSS_CR1_ACK 4
`define I2CSS_CR1_RESET 8'h00
`define I2CSS_OWN_RESET 7'h00
`define I2CSS_IRQ_EVENT 0
`define I2CSS_IRQ_STOP 1
`define I2CSS_HALF_NS 5000
`define I2CSS_CLK_NS 40
`define I2CSS_HALF_CYC ((`I2CSS_HALF_NS + `I2CSS_CLK_NS - 1) / `I2CSS_CLK_NS)
`endif

// ===== design/i2css_pkg.sv
// Types of the two-wire slave, stop and restart block
package i2css_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_A, ST_WAIT, ST_DATA, ST_ACK_D, ST_STOP_A, ST_STOP_B, ST_STOP_C,
    ST_LOST
  } i2css_state_e;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } i2css_req_s;
  typedef struct packed {
    logic trx;
    logic al;
    logic aas;
    logic ad0;
    logic lrb;
  } i2css_flags_s;
endpackage : i2css_pkg

// ===== design/i2css_top.sv
// Two-wire slave event, stop generation and restart logic
`timescale 1ns/100ps
`include "i2css_map.svh"
module i2css_top (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_out,
  output logic o_scl_oe,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_irq
);
  typedef struct packed {
    i2css_pkg::i2css_state_e st;
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_d;
    logic sda_d;
    logic [7:0] cr1;
    logic master_select;
    logic trx;
    logic bb;
    logic pin;
    i2css_pkg::i2css_flags_s fl;
    logic [6:0] own;
    logic [7:0] shreg;
    logic [7:0] dbuf;
    logic [3:0] bitn;
    logic [2:0] bc;
    logic rw;
    logic [7:0] tmr;
    logic [1:0] ist;
    logic [1:0] imask;
    logic [7:0] rdata;
    logic scl_oe;
    logic sda_oe;
    logic irq;
  } i2css_state_s;

  i2css_state_s r;
  i2css_state_s next_r;
  i2css_pkg::i2css_req_s req;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic dbuf_acc;
  logic [7:0] sr_rd;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  function automatic logic [3:0] bits_of(input logic [2:0] bc);
    bits_of = (bc == 3'h0) ? 4'h8 : {1'b0, bc};
  endfunction : bits_of

  function automatic logic is_cr2_write(input i2css_pkg::i2css_req_s q);
    is_cr2_write = q.wr && (q.addr == `I2CSS_ADDR_CTRL2);
  endfunction : is_cr2_write

  assign scl_rise = r.scl_s[1] && !r.scl_d;
  assign scl_fall = !r.scl_s[1] && r.scl_d;
  assign start_c = r.scl_s[1] && r.scl_d && !r.sda_s[1] && r.sda_d;
  assign stop_c = r.scl_s[1] && r.scl_d && r.sda_s[1] && !r.sda_d;
  assign dbuf_acc = (req.wr || req.rd) && (req.addr == `I2CSS_ADDR_DATA);
  assign sr_rd = {r.master_select, r.trx, r.bb, r.pin, r.fl.al, r.fl.aas, r.fl.ad0, r.fl.lrb};

  always_comb begin
    next_r = r;
    next_r.scl_s = {r.scl_s[0], i_scl};
    next_r.sda_s = {r.sda_s[0], i_sda};
    next_r.scl_d = r.scl_s[1];
    next_r.sda_d = r.sda_s[1];
    next_r.rdata = 8'h00;
    if (req.rd) begin
      case (req.addr)
        `I2CSS_ADDR_CTRL1: next_r.rdata = r.cr1;
        `I2CSS_ADDR_CTRL2, `I2CSS_ADDR_STATUS: next_r.rdata = sr_rd;
        `I2CSS_ADDR_DATA: next_r.rdata = r.dbuf;
        `I2CSS_ADDR_OWN: next_r.rdata = {r.own, 1'b0};
        `I2CSS_ADDR_IRQ_STAT: next_r.rdata = {6'h00, r.ist};
        `I2CSS_ADDR_IRQ_MASK: next_r.rdata = {6'h00, r.imask};
        default: next_r.rdata = 8'h00;
      endcase
    end
    if (req.wr) begin
      case (req.addr)
        `I2CSS_ADDR_CTRL1: begin
          next_r.cr1 = req.wdata;
          next_r.bc = req.wdata[7:5];
        end
        `I2CSS_ADDR_DATA: next_r.dbuf = req.wdata;
        `I2CSS_ADDR_OWN: next_r.own = req.wdata[7:1];
        `I2CSS_ADDR_IRQ_STAT: next_r.ist = r.ist & ~req.wdata[1:0];
        `I2CSS_ADDR_IRQ_MASK: next_r.imask = req.wdata[1:0];
        default: next_r.ist = next_r.ist;
      endcase
    end
    // Buffer access releases the held clock line
    if (dbuf_acc && !r.pin) begin
      next_r.pin = 1'b1;
      next_r.scl_oe = 1'b0;
      next_r.shreg = req.wr ? req.wdata : r.dbuf;
      next_r.sda_oe = r.trx && !next_r.shreg[7];
      next_r.bitn = 4'h0;
      next_r.st = ((r.st == i2css_pkg::ST_WAIT) && r.trx) ? i2css_pkg::ST_DATA : r.st;
      if (r.st == i2css_pkg::ST_WAIT && !r.trx) begin
        next_r.st = i2css_pkg::ST_DATA;
      end
    end
    if (is_cr2_write(req)) begin
      if (req.wdata[`I2CSS_CR2_MST] && req.wdata[`I2CSS_CR2_TRX] &&
          req.wdata[`I2CSS_CR2_PIN] && !req.wdata[`I2CSS_CR2_BB] && r.bb) begin
        next_r.master_select = 1'b1;
        next_r.trx = 1'b1;
        next_r.pin = 1'b1;
        next_r.tmr = 8'h00;
        next_r.st = i2css_pkg::ST_STOP_A;
      end else if (!req.wdata[`I2CSS_CR2_MST] && !req.wdata[`I2CSS_CR2_TRX] &&
                   !req.wdata[`I2CSS_CR2_BB] && req.wdata[`I2CSS_CR2_PIN]) begin
        next_r.master_select = 1'b0;
        next_r.trx = 1'b0;
        next_r.pin = 1'b1;
        next_r.scl_oe = 1'b0;
        next_r.sda_oe = 1'b0;
        next_r.st = i2css_pkg::ST_IDLE;
      end else if (req.wdata[`I2CSS_CR2_PIN] && !r.pin) begin
        next_r.pin = 1'b1;
        next_r.scl_oe = 1'b0;
        if (r.st == i2css_pkg::ST_WAIT) begin
          next_r.st = i2css_pkg::ST_IDLE;
          next_r.trx = req.wdata[`I2CSS_CR2_TRX];
        end
      end
    end
    // Bus-busy follows start and stop seen on the line
    if (start_c) begin
      next_r.bb = 1'b1;
      next_r.st = i2css_pkg::ST_ADDR;
      next_r.bitn = 4'h0;
      next_r.shreg = 8'h00;
    end
    if (stop_c) begin
      next_r.bb = 1'b0;
      next_r.sda_oe = 1'b0;
      next_r.ist[`I2CSS_IRQ_STOP] = 1'b1;
      if (r.st != i2css_pkg::ST_STOP_C) begin
        next_r.st = i2css_pkg::ST_IDLE;
      end
    end
    case (r.st)
      i2css_pkg::ST_IDLE: next_r.tmr = 8'h00;
      i2css_pkg::ST_ADDR: begin
        if (scl_rise) begin
          next_r.shreg = {r.shreg[6:0], r.sda_s[1]};
          next_r.bitn = r.bitn + 4'h1;
        end
        if (scl_fall && r.bitn == 4'h8) begin
          if (r.shreg[7:1] == r.own || r.shreg[7:1] == 7'h00) begin
            next_r.sda_oe = 1'b1;
            next_r.rw = r.shreg[0];
            next_r.fl.ad0 = (r.shreg[7:1] == 7'h00);
            next_r.st = i2css_pkg::ST_ACK_A;
          end else begin
            next_r.st = i2css_pkg::ST_IDLE;
          end
        end
      end
      i2css_pkg::ST_ACK_A: if (scl_fall) begin
        next_r.sda_oe = 1'b0;
        next_r.trx = r.rw && !r.fl.ad0;
        next_r.fl.aas = 1'b1;
        next_r.fl.al = r.master_select;
        next_r.master_select = 1'b0;
        next_r.fl.ad0 = r.rw ? 1'b0 : r.fl.ad0;
        next_r.pin = 1'b0;
        next_r.scl_oe = 1'b1;
        next_r.ist[`I2CSS_IRQ_EVENT] = 1'b1;
        next_r.st = i2css_pkg::ST_WAIT;
      end
      i2css_pkg::ST_WAIT: next_r.bitn = 4'h0;
      i2css_pkg::ST_DATA: begin
        // Next bit goes out only after the clock line has fallen
        if (scl_fall && r.bitn < bits_of(r.bc)) begin
          next_r.sda_oe = r.trx && !r.shreg[7];
        end
        if (scl_rise) begin
          next_r.shreg = {r.shreg[6:0], r.sda_s[1]};
          next_r.bitn = r.bitn + 4'h1;
          if (r.trx && r.shreg[7] && !r.sda_s[1]) begin
            next_r.fl.al = 1'b1;
            next_r.trx = 1'b0;
            next_r.st = i2css_pkg::ST_LOST;
          end
        end
        if (scl_fall && r.bitn == bits_of(r.bc)) begin
          next_r.sda_oe = !r.trx && r.cr1[`I2CSS_CR1_ACK];
          next_r.st = i2css_pkg::ST_ACK_D;
          if (!r.trx) begin
            next_r.dbuf = r.shreg;
          end
        end
      end
      i2css_pkg::ST_ACK_D: begin
        if (scl_rise) begin
          next_r.fl.lrb = r.sda_s[1];
        end
        if (scl_fall) begin
          next_r.sda_oe = 1'b0;
          next_r.fl.aas = 1'b0;
          next_r.fl.al = 1'b0;
          next_r.fl.ad0 = 1'b0;
          next_r.pin = 1'b0;
          next_r.scl_oe = 1'b1;
          next_r.ist[`I2CSS_IRQ_EVENT] = 1'b1;
          next_r.st = i2css_pkg::ST_WAIT;
        end
      end
      i2css_pkg::ST_LOST: if (scl_fall && r.bitn == bits_of(r.bc)) begin
        next_r.fl.aas = 1'b0;
        next_r.fl.ad0 = 1'b0;
        next_r.pin = 1'b0;
        next_r.scl_oe = 1'b1;
        next_r.ist[`I2CSS_IRQ_EVENT] = 1'b1;
        next_r.st = i2css_pkg::ST_WAIT;
      end else if (scl_rise) begin
        next_r.bitn = r.bitn + 4'h1;
      end
      i2css_pkg::ST_STOP_A: begin
        next_r.sda_oe = 1'b1;
        next_r.scl_oe = 1'b0;
        if (r.scl_s[1]) begin
          next_r.tmr = r.tmr + 8'h01;
        end else begin
          next_r.tmr = 8'h00;
        end
        if (r.scl_s[1] && r.tmr == 8'(`I2CSS_HALF_CYC)) begin
          next_r.tmr = 8'h00;
          next_r.st = i2css_pkg::ST_STOP_B;
        end
      end
      i2css_pkg::ST_STOP_B: begin
        next_r.sda_oe = 1'b0;
        next_r.st = i2css_pkg::ST_STOP_C;
      end
      i2css_pkg::ST_STOP_C: if (stop_c || r.sda_s[1]) begin
        next_r.master_select = 1'b0;
        next_r.trx = 1'b0;
        next_r.st = i2css_pkg::ST_IDLE;
      end
      default: next_r.st = i2css_pkg::ST_IDLE;
    endcase
    next_r.irq = |(next_r.ist & r.imask);
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r <= '0;
      r.scl_s <= 2'h3;
      r.sda_s <= 2'h3;
      r.scl_d <= 1'b1;
      r.sda_d <= 1'b1;
      r.pin <= 1'b1;
      r.cr1 <= `I2CSS_CR1_RESET;
      r.own <= `I2CSS_OWN_RESET;
      r.st <= i2css_pkg::ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign o_rdata = r.rdata;
  assign o_scl_out = 1'b0;
  assign o_scl_oe = r.scl_oe;
  assign o_sda_out = 1'b0;
  assign o_sda_oe = r.sda_oe;
  assign o_irq = r.irq;

  property p_hold_scl;
    @(posedge i_clk) disable iff (!i_resetn) $fell(r.pin) |-> r.scl_oe;
  endproperty
  a_hold_scl: assert property (p_hold_scl) else $error("clock not held on event");

  property p_stop_wait;
    @(posedge i_clk) disable iff (!i_resetn)
      (r.st == i2css_pkg::ST_STOP_A && !r.scl_s[1]) |=> r.st != i2css_pkg::ST_STOP_B;
  endproperty
  a_stop_wait: assert property (p_stop_wait) else $error("stop while clock held");

  property p_stop_start;
    @(posedge i_clk) disable iff (!i_resetn)
      (is_cr2_write(req) && req.wdata[7:4] == 4'hd && r.bb && r.st != i2css_pkg::ST_ADDR
       && !start_c && !stop_c) |=> r.st == i2css_pkg::ST_STOP_A;
  endproperty
  a_stop_start: assert property (p_stop_start) else $error("stop not started");

  property p_release;
    @(posedge i_clk) disable iff (!i_resetn)
      (is_cr2_write(req) && req.wdata[7:4] == 4'h1 && !start_c) |=> !r.scl_oe && !r.sda_oe;
  endproperty
  a_release: assert property (p_release) else $error("release left a line low");

  property p_rd_addr;
    @(posedge i_clk) disable iff (!i_resetn)
      ($fell(r.pin) && r.fl.aas && r.rw) |-> r.trx && !r.fl.ad0;
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("read address flags wrong");

  property p_wr_addr;
    @(posedge i_clk) disable iff (!i_resetn)
      ($fell(r.pin) && r.fl.aas && !r.rw) |-> !r.trx;
  endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("write address flags wrong");

  property p_word_done;
    @(posedge i_clk) disable iff (!i_resetn)
      ($fell(r.pin) && !r.fl.aas) |-> !r.fl.ad0;
  endproperty
  a_word_done: assert property (p_word_done) else $error("word flags wrong");

  property p_stable;
    @(posedge i_clk) disable iff (!i_resetn)
      (r.st == i2css_pkg::ST_WAIT && !req.wr && !req.rd && !start_c && !stop_c)
      |=> $stable(r.fl);
  endproperty
  a_stable: assert property (p_stable) else $error("flags moved while waiting");

  property p_irq;
    @(posedge i_clk) disable iff (!i_resetn) o_irq == |(r.ist & $past(r.imask));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_buf_release;
    @(posedge i_clk) disable iff (!i_resetn)
      (dbuf_acc && !r.pin) |=> r.pin && !r.scl_oe;
  endproperty
  a_buf_release: assert property (p_buf_release) else $error("buffer access kept clock held");

  property p_tx_steady;
    @(posedge i_clk) disable iff (!i_resetn)
      (r.st == i2css_pkg::ST_DATA && r.scl_s[1] && r.scl_d && !req.wr && !req.rd && !stop_c)
      |=> $stable(r.sda_oe);
  endproperty
  a_tx_steady: assert property (p_tx_steady) else $error("data moved while clock high");
endmodule : i2css_top

// ===== tb/i2css_bus_model.sv
// Behavioural master on the far side of the two-wire bus
`timescale 1ns/100ps
module i2css_bus_model (
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_oe,
  output logic o_sda_oe
);
  initial begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
  end
  // Moves to a falling clock edge so bus changes never race the sampling edge
  task automatic align();
    #((40 - $time % 40) % 40);
  endtask : align
  task automatic rise_scl();
    o_scl_oe = 1'b0;
    for (int k = 0; k < 8000 && i_scl !== 1'b1; k++) #40;
  endtask : rise_scl
  task automatic release_scl();
    align();
    o_scl_oe = 1'b0;
  endtask : release_scl
  task automatic bit_cycle(input logic b, output logic s);
    align();
    o_sda_oe = !b;
    #120;
    rise_scl();
    #160;
    s = i_sda;
    o_scl_oe = 1'b1;
    #40;
  endtask : bit_cycle
  task automatic start_cond();
    align();
    o_sda_oe = 1'b1;
    #160;
    o_scl_oe = 1'b1;
    #160;
  endtask : start_cond
  task automatic stop_cond();
    align();
    o_sda_oe = 1'b1;
    #160;
    rise_scl();
    #160;
    o_sda_oe = 1'b0;
    #160;
  endtask : stop_cond
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
    bit_cycle(1'b1, s);
    ack = !s;
  endtask : send_byte
  task automatic recv_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, s);
      b[i] = s;
    end
    bit_cycle(nack, s);
  endtask : recv_byte
endmodule : i2css_bus_model

// ===== tb/tb_top.sv
// Self-checking bench for the two-wire slave, stop and restart block
`timescale 1ns/100ps
`include "i2css_map.svh"
module tb_top;
  localparam logic [2:0] STS = `I2CSS_ADDR_STATUS;
  localparam logic [2:0] DAT = `I2CSS_ADDR_DATA;
  localparam logic [2:0] IST = `I2CSS_ADDR_IRQ_STAT;
  localparam logic [2:0] MSK = `I2CSS_ADDR_IRQ_MASK;
  localparam logic [2:0] CR2 = `I2CSS_ADDR_CTRL2;
  typedef struct packed {logic [7:0] adr; logic [7:0] exp; logic [7:0] care;} i2css_row_s;
  logic i_clk, i_resetn, i_wr, i_rd, ack;
  logic [2:0] i_addr;
  logic [7:0] i_wdata, o_rdata, d;
  logic o_scl_out, o_scl_oe, o_sda_out, o_sda_oe, o_irq, m_scl_oe, m_sda_oe;
  wire scl = !(o_scl_oe || m_scl_oe);
  wire sda = !(o_sda_oe || m_sda_oe);
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  int k;
  i2css_row_s rows [3] = '{'{8'hA0, 8'h04, 8'h5C}, '{8'hA1, 8'h44, 8'h5E},
    '{8'h00, 8'h04, 8'h5C}};
  i2css_top uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_scl(scl), .i_sda(sda),
    .o_scl_out(o_scl_out), .o_scl_oe(o_scl_oe), .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe), .o_irq(o_irq));
  i2css_bus_model u_bus (.i_scl(scl), .i_sda(sda), .o_scl_oe(m_scl_oe), .o_sda_oe(m_sda_oe));
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : rd
  task automatic wait_irq();
    for (k = 0; k < 4000 && o_irq !== 1'b1; k++) @(negedge i_clk);
    chk("irq", {7'h00, o_irq}, 8'h01);
  endtask : wait_irq
  task automatic tally_and_finish();
    $display("Compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = !i_clk;
  end
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    i_resetn = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 3'h0;
    i_wdata = 8'h00;
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    chk("reset lines", {4'h0, o_scl_oe, o_sda_oe, o_irq, o_scl_out}, 8'h00);
    rd(3'h7, d);
    chk("unmapped", d, 8'h00);
    wr(`I2CSS_ADDR_OWN, 8'hA0);
    wr(MSK, 8'h01);
    for (int i = 0; i < 3; i++) begin
      u_bus.start_cond();
      u_bus.send_byte(rows[i].adr, ack);
      chk("ack", {7'h00, ack}, 8'h01);
      wait_irq();
      chk("hold", {7'h00, o_scl_oe}, 8'h01);
      rd(STS, d);
      chk("status", d & rows[i].care, rows[i].exp);
      wr(IST, 8'h01);
      rd(STS, d);
      chk("status again", d & rows[i].care, rows[i].exp);
      chk("irq clear", {7'h00, o_irq}, 8'h00);
      wr(DAT, 8'hFF);
      u_bus.stop_cond();
      wr(IST, 8'h02);
    end
    wr(MSK, 8'h00);
    u_bus.start_cond();
    u_bus.send_byte(8'hA0, ack);
    repeat (20) @(posedge i_clk);
    chk("masked", {6'h00, o_irq, o_scl_oe}, 8'h01);
    rd(IST, d);
    chk("sticky", d & 8'h01, 8'h01);
    wr(MSK, 8'h01);
    wait_irq();
    wr(IST, 8'h01);
    rd(DAT, d);
    fork
      u_bus.send_byte(8'h5A, ack);
      begin
        wait_irq();
        rd(STS, d);
        chk("rx status", d & 8'h4C, 8'h00);
        rd(DAT, d);
        chk("rx data", d, 8'h5A);
      end
    join
    wr(IST, 8'h01);
    u_bus.stop_cond();
    u_bus.start_cond();
    u_bus.send_byte(8'hA1, ack);
    wait_irq();
    wr(IST, 8'h01);
    wr(DAT, 8'h3C);
    u_bus.recv_byte(1'b1, d);
    chk("tx data", d, 8'h3C);
    wait_irq();
    rd(STS, d);
    chk("tx status", d & 8'h4F, 8'h41);
    wr(IST, 8'h01);
    wr(CR2, 8'h10);
    repeat (8) @(posedge i_clk);
    chk("free lines", {6'h00, o_scl_oe, o_sda_oe}, 8'h00);
    u_bus.stop_cond();
    wr(IST, 8'h02);
    u_bus.start_cond();
    u_bus.send_byte(8'h44, ack);
    chk("no ack", {7'h00, ack}, 8'h00);
    rd(STS, d);
    chk("busy", d & 8'h20, 8'h20);
    wr(CR2, 8'hD0);
    repeat (200) @(posedge i_clk);
    chk("stop held", {6'h00, o_sda_oe, scl}, 8'h02);
    u_bus.release_scl();
    for (k = 0; k < 400 && o_sda_oe !== 1'b0; k++) @(negedge i_clk);
    chk("stop delay", {7'h00, (k >= 120 && k < 140)}, 8'h01);
    repeat (4) @(posedge i_clk);
    rd(STS, d);
    chk("bus free", d & 8'h20, 8'h00);
    rd(IST, d);
    chk("stop seen", d & 8'h02, 8'h02);
    rd(STS, d);
    chk("restart free", d & 8'h21, 8'h01);
    repeat (118) @(posedge i_clk);
    wr(`I2CSS_ADDR_CTRL1, 8'h10);
    wr(DAT, 8'hA2);
    wr(CR2, 8'hF0);
    rd(DAT, d);
    chk("restart address", d, 8'hA2);
    tally_and_finish();
  end
endmodule : tb_top
